// ---- bench/host_dma_model.sv ----
`timescale 1ns/1ns
`default_nettype none

// ==========================================
// host cpu and dma controller, driven at the falling edge
module host_dma_model
    import host_port_pkg::*;
(
    input  wire logic              clk,
    input  wire logic [DATA_W-1:0] db_out,
    input  wire logic              dma_request,
    output logic                   cs_n,
    output logic                   rd_n,
    output logic                   wr_n,
    output logic      [SEL_W-1:0]  reg_select,
    output logic      [DATA_W-1:0] db_in,
    output logic                   dma_grant_n
);
    // idle pins; pull-ups hold the released bus high
    initial begin
        {cs_n, rd_n, wr_n, dma_grant_n} = 4'hf;
        reg_select = 4'h0;
        db_in = 8'hff;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask

    // register access, grant held off throughout
    task automatic reg_acc(input logic wr, input logic [3:0] sel,
            input logic [7:0] d, input logic late, output logic [7:0] q);
        tick(1);
        reg_select = sel; // one chip select cycle per address
        cs_n = 1'b0;
        if (wr) begin
            wr_n = 1'b0;
            db_in = d;
        end else begin
            rd_n = 1'b0;
        end
        tick(5);
        q = db_out;
        // late: chip select ends the cycle while the strobe stays low
        if (late) cs_n = 1'b1;
        else {rd_n, wr_n} = 2'b11;
        tick(2);
        {cs_n, rd_n, wr_n} = 3'b111;
        db_in = 8'hff;
        tick(6);
    endtask

    // one byte per grant cycle, chip select kept off
    task automatic dma_byte(input logic [7:0] d, output logic ok);
        int n;
        n = 0;
        while (dma_request !== 1'b1 && n < 60) begin
            tick(1);
            n++;
        end
        ok = (dma_request === 1'b1);
        if (ok) begin
            dma_grant_n = 1'b0;
            wr_n = 1'b0;
            db_in = d;
            tick(2); // grant low for two periods
            {dma_grant_n, wr_n} = 2'b11;
            db_in = 8'hff;
            tick(5); // let the push land before looking at request
        end
    endtask
endmodule

`default_nettype wire

// ---- bench/host_port_monitor.sv ----
`timescale 1ns/1ns
`default_nettype none

// ==========================================
// pin level checks on the host port
module host_port_monitor
    import host_port_pkg::*;
(
    input wire logic             clk,
    input wire logic             reset,
    input wire logic             reset_echo_out,
    input wire logic             cs_n,
    input wire logic             rd_n,
    input wire logic             wr_n,
    input wire logic [SEL_W-1:0] reg_select,
    input wire logic [SEL_W-1:0] reg_addr,
    input wire logic             db_oe,
    input wire logic             int_n,
    input wire logic             irq_event,
    input wire logic             dma_grant_n,
    input wire logic             dma_request,
    input wire logic             dma_write_en,
    input wire logic             reg_wr_pulse,
    input wire logic             reg_rd_done
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    // a read long enough to pass the synchroniser
    sequence rd_live;
        (!cs_n && !rd_n && dma_grant_n) [*4];
    endsequence
    // a write whose strobe ends, whether or not chip select rises with it
    sequence wr_end;
        (!cs_n && !wr_n && dma_grant_n) [*3] ##1 (wr_n && dma_grant_n);
    endsequence

    echo_fall_a: assert property ($fell(reset) |=> !reset_echo_out)
        else $error("echo output stuck high");
    read_drive_a: assert property (rd_live |=> db_oe)
        else $error("read data not driven");
    read_release_a: assert property ((cs_n || rd_n) [*4] |=> !db_oe)
        else $error("read data not released");
    alert_clear_a: assert property (
        rd_live ##0 reg_select == ISR_SELECT |=> int_n)
        else $error("alert not cleared by status read");
    alert_hold_a: assert property ($rose(rd_n) && !cs_n && int_n &&
        reg_select == ISR_SELECT |=> int_n [*2])
        else $error("alert raised too soon");
    alert_set_a: assert property (
        (cs_n && rd_n) [*8] ##0 irq_event |=> !int_n)
        else $error("event did not raise alert");
    addr_latch_a: assert property ((!cs_n && $stable(reg_select)) [*4]
        |=> reg_addr == $past(reg_select))
        else $error("address not latched");
    rd_done_a: assert property (rd_live ##1 (cs_n || rd_n) [*3] |=>
        reg_rd_done) else $error("read end not reported");
    wr_commit_a: assert property (wr_end |-> ##[2:5] reg_wr_pulse)
        else $error("write not committed");
    req_hold_a: assert property ((dma_write_en && dma_grant_n) [*6]
        ##0 dma_request |=> dma_request)
        else $error("request dropped with room left");
    req_return_a: assert property ($rose(dma_request)
        |-> $past(dma_grant_n, 2) && $past(dma_grant_n, 3))
        else $error("request raised with grant active");
endmodule

bind scsi_ctrl_host_bus_port host_port_monitor mon (.*);

`default_nettype wire

// ---- bench/scsi_ctrl_host_bus_port_tb.sv ----
`timescale 1ns/1ns
`default_nettype none

// ==========================================
// self checking bench
module scsi_ctrl_host_bus_port_tb
    import host_port_pkg::*;
;
    logic              clk, reset, dma_write_en, irq_event, scsi_ready;
    logic              reset_echo_out, db_oe, int_n, dma_request;
    logic              cs_n, rd_n, wr_n, dma_grant_n, reg_rd_done;
    logic              reg_wr_pulse, scsi_valid, drain, ok;
    logic [SEL_W-1:0]  reg_select, reg_addr;
    logic [DATA_W-1:0] db_in, db_out, reg_rd_data, reg_wr_data, scsi_data;
    logic [DATA_W-1:0] d, q, core [16], mdl [16];
    logic [DATA_W-1:0] fq [$];
    int                i, n, seed, fail_count, samples_checked;

    scsi_ctrl_host_bus_port #(.DEPTH(FIFO_DEPTH)) uut (.*);
    host_dma_model host (.*);

    always #(CLK_PERIOD_NS / 2) clk = ~clk;

    // core register file behind the port
    assign reg_rd_data = core[reg_addr];
    always @(posedge clk) if (reg_wr_pulse) core[reg_addr] <= reg_wr_data;

    // scsi side drains at random when allowed, checked in order
    always @(negedge clk) scsi_ready <= drain ? 1'($random(seed)) : 1'b0;
    always @(posedge clk) if (!reset && scsi_valid && scsi_ready)
        chk(scsi_data, fq.pop_front());

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic summarize;
        $display("checked %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic alert_pulse;
        host.tick(4);
        irq_event = 1'b1;
        host.tick(1);
        irq_event = 1'b0;
        host.tick(2);
    endtask

    // watchdog, far beyond the expected thousand or so cycles
    initial begin
        #(20000 * CLK_PERIOD_NS);
        fail_count++;
        $display("Error at %0t: timeout", $time);
        summarize();
    end

    initial begin
        {clk, reset, dma_write_en, irq_event, drain} = 5'b01000;
        {seed, fail_count, samples_checked} = {32'h9600, 64'h0};
        repeat (12) @(negedge clk);
        chk(reset_echo_out, 1);
        reset = 1'b0;
        host.tick(2);
        chk(reset_echo_out, 0);
        chk(int_n, 1);
        $display("reset test done");
        // writes alternate which pin ends the cycle
        // random core events and dma mode ride along; the grant
        // stays off, so neither may disturb the register traffic
        for (i = 0; i < 16; i++) begin
            mdl[i] = 8'($random(seed));
            {irq_event, dma_write_en} = 2'($random(seed));
            host.reg_acc(1'b1, i[3:0], mdl[i], i[0], q);
        end
        {irq_event, dma_write_en} = 2'b00;
        // the status register is not read while the alert is on
        for (i = 0; i < 16; i++) if (i != ISR_SELECT) begin
            host.reg_acc(1'b0, i[3:0], 8'h00, 1'b0, q);
            chk(q, mdl[i]);
            chk(db_oe, 0);
        end
        $display("register test done");
        alert_pulse();
        chk(int_n, 0);
        host.reg_acc(1'b0, 4'h3, 8'h00, 1'b0, q);
        chk(int_n, 0);
        host.reg_acc(1'b0, ISR_SELECT, 8'h00, 1'b0, q);
        chk(q, mdl[ISR_SELECT]);
        chk(int_n, 1);
        alert_pulse();
        chk(int_n, 0);
        host.reg_acc(1'b0, ISR_SELECT, 8'h00, 1'b0, q);
        chk(int_n, 1);
        $display("interrupt test done");
        // fill the fifo with the scsi side stalled
        dma_write_en = 1'b1;
        host.tick(4);
        {n, ok} = {32'h0, 1'b1};
        while (ok) begin
            d = 8'($random(seed));
            fq.push_back(d);
            host.dma_byte(d, ok);
            if (ok) n++;
            else d = fq.pop_back();
        end
        chk(8'(n), 8'(FIFO_DEPTH));
        chk(dma_request, 0);
        // drain while writing more
        drain = 1'b1;
        for (i = 0; i < 20; i++) begin
            d = 8'($random(seed));
            fq.push_back(d);
            host.dma_byte(d, ok);
            chk(ok, 1);
        end
        n = 0;
        while (fq.size() != 0 && n < 500) begin
            host.tick(1);
            n++;
        end
        host.tick(2);
        chk(8'(fq.size()), 0);
        chk(scsi_valid, 0);
        $display("dma test done");
        summarize();
    end
endmodule

`default_nettype wire

// ---- inc/host_port_pkg.sv ----
`default_nettype none
package host_port_pkg;
    // ==========================================
    // clock and derived timing
    localparam int CLK_PERIOD_NS      = 50;
    localparam int CLK_LOW_NS         = 25;
    localparam int RESET_ECHO_MAX_NS  = 50;
    localparam int ALERT_CLEAR_MAX_NS = 100;
    localparam int SYNC_LATENCY_NS    = CLK_PERIOD_NS + CLK_LOW_NS;
    // least time: round up
    localparam int SYNC_LATENCY_CYC   =
        (SYNC_LATENCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // longest times: round down, the echo count never below one
    localparam int RESET_ECHO_CYC     =
        (RESET_ECHO_MAX_NS / CLK_PERIOD_NS < 1) ? 1 :
        RESET_ECHO_MAX_NS / CLK_PERIOD_NS;
    localparam int ALERT_CLEAR_CYC    = ALERT_CLEAR_MAX_NS / CLK_PERIOD_NS;

    // ==========================================
    // widths, depth, offsets, reset values
    localparam int DATA_W             = 8;
    localparam int SEL_W              = 4;
    localparam int FIFO_DEPTH         = 32;
    localparam int SYNC_STAGES        = 2;
    localparam logic [3:0] ISR_SELECT = 4'h5;
    localparam logic [7:0] DATA_RST   = 8'h00;
    localparam logic [3:0] SEL_RST    = 4'h0;
    localparam logic [1:0] HOLD_W_RST = 2'h0;
    localparam logic [1:0] HOLD_LOAD  = 2'(SYNC_LATENCY_CYC);
endpackage
`default_nettype wire

// ---- logic/scsi_ctrl_host_bus_port.sv ----
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// byte fifo between the dma write port and the scsi side
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
    localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr_reg;
    logic [PW-1:0]    rd_ptr_reg;
    logic [CW-1:0]    count_reg;
    wire              push;
    wire              pop;
    // honest flags straight from the occupancy count
    assign in_ready  = (count_reg != FULL_CNT);
    assign out_valid = (count_reg != '0);
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    assign out_data  = mem[rd_ptr_reg];
    // storage has no reset, only the pointers and the count need one
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end
    // pointer wrap works for any depth, not just powers of two
    always_ff @(posedge clk) begin
        if (reset) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == LAST_PTR) ? '0 :
                              PW'(wr_ptr_reg + 1'b1);
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == LAST_PTR) ? '0 :
                              PW'(rd_ptr_reg + 1'b1);
            end
            if (push && !pop) begin
                count_reg <= CW'(count_reg + 1'b1);
            end else if (pop && !push) begin
                count_reg <= CW'(count_reg - 1'b1);
            end
        end
    end
endmodule
// ==========================================
// two flop synchroniser for a bundle of pin inputs
module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] pin,
    output logic      [WIDTH-1:0] synced
);
    logic [WIDTH-1:0] meta_reg;
    // first stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (reset) begin
            meta_reg <= INIT;
            synced   <= INIT;
        end else begin
            meta_reg <= pin;
            synced   <= meta_reg;
        end
    end
endmodule
// ==========================================
// Functional notes
// - reset echo output follows reset input
// - interrupt status read drops the alert
// - alert re-raise waits one sync latency
// - address latched when chip select asserts
// - write strobe either order, commit at end
// - read drive while select and strobe low
// - dma request held while fifo has room, dropped a cycle after each push
// - after full, re-request only grant inactive
// - dma write byte taken when cycle ends
module scsi_ctrl_host_bus_port
    import host_port_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic              clk,
    input  wire logic              reset,
    output logic                   reset_echo_out,
    input  wire logic              cs_n,
    input  wire logic              rd_n,
    input  wire logic              wr_n,
    input  wire logic [SEL_W-1:0]  reg_select,
    input  wire logic [DATA_W-1:0] db_in,
    output logic      [DATA_W-1:0] db_out,
    output logic                   db_oe,
    output logic                   int_n,
    input  wire logic              dma_grant_n,
    output logic                   dma_request,
    input  wire logic              dma_write_en,
    input  wire logic              irq_event,
    output logic      [SEL_W-1:0]  reg_addr,
    input  wire logic [DATA_W-1:0] reg_rd_data,
    output logic                   reg_rd_done,
    output logic                   reg_wr_pulse,
    output logic      [DATA_W-1:0] reg_wr_data,
    output logic      [DATA_W-1:0] scsi_data,
    output logic                   scsi_valid,
    input  wire logic              scsi_ready
);
    // ==========================================
    // pin synchronisers
    localparam int PINS_W = 4 + SEL_W + DATA_W;
    logic [PINS_W-1:0] pins_s;
    wire               cs_s;
    wire               rd_s;
    wire               wr_s;
    wire               grant_s;
    wire [SEL_W-1:0]   sel_s;
    wire [DATA_W-1:0]  db_s;
    // data and address ride with the strobes so they stay aligned
    pin_sync #(
        .WIDTH (PINS_W),
        .INIT  ({4'hf, SEL_RST, DATA_RST})
    ) u_sync (
        .clk    (clk),
        .reset  (reset),
        .pin    ({cs_n, rd_n, wr_n, dma_grant_n, reg_select, db_in}),
        .synced (pins_s)
    );
    // active high views of the synchronised strobes
    assign cs_s    = ~pins_s[PINS_W-1];
    assign rd_s    = ~pins_s[PINS_W-2];
    assign wr_s    = ~pins_s[PINS_W-3];
    assign grant_s = ~pins_s[PINS_W-4];
    assign sel_s   = pins_s[DATA_W +: SEL_W];
    assign db_s    = pins_s[DATA_W-1:0];
    // ==========================================
    // reset echo
    // one flop keeps the echo inside a single 50 ns period
    always_ff @(posedge clk) begin
        reset_echo_out <= reset;
    end
    // ==========================================
    // register access decode
    logic             cs_d_reg;
    logic             rd_act_reg;
    logic             wr_act_reg;
    logic [SEL_W-1:0] addr_reg;
    wire              cs_rise;
    wire              rd_act;
    wire              wr_act;
    wire              rd_end;
    wire              wr_end;
    wire              isr_hit;
    wire              isr_start;
    wire  [SEL_W-1:0] cur_addr;
    // an access is live only while select and its strobe overlap
    assign cs_rise   = cs_s & ~cs_d_reg;
    assign rd_act    = cs_s & rd_s;
    assign wr_act    = cs_s & wr_s;
    assign rd_end    = rd_act_reg & ~rd_act;
    assign wr_end    = wr_act_reg & ~wr_act;
    // the select edge may share its cycle with the first strobe
    assign cur_addr  = cs_rise ? sel_s : addr_reg;
    assign isr_hit   = (cur_addr == ISR_SELECT);
    assign isr_start = rd_act & ~rd_act_reg & isr_hit;
    // address taken on the select edge only, so a changed
    // address needs a fresh select cycle
    always_ff @(posedge clk) begin
        if (reset) begin
            addr_reg <= SEL_RST;
        end else if (cs_rise) begin
            addr_reg <= sel_s;
        end
    end
    // edge history of the decoded accesses
    always_ff @(posedge clk) begin
        if (reset) begin
            cs_d_reg   <= 1'b0;
            rd_act_reg <= 1'b0;
            wr_act_reg <= 1'b0;
        end else begin
            cs_d_reg   <= cs_s;
            rd_act_reg <= rd_act;
            wr_act_reg <= wr_act;
        end
    end
    assign reg_addr = addr_reg;
    // ==========================================
    // register write path
    logic [DATA_W-1:0] wdata_reg;
    logic              wr_pulse_reg;
    // keep sampling during the overlap; the last sample before
    // whichever strobe ends first is the one committed
    always_ff @(posedge clk) begin
        if (reset) begin
            wdata_reg    <= DATA_RST;
            wr_pulse_reg <= 1'b0;
        end else begin
            if (wr_act) begin
                wdata_reg <= db_s;
            end
            wr_pulse_reg <= wr_end;
        end
    end
    assign reg_wr_pulse = wr_pulse_reg;
    assign reg_wr_data  = wdata_reg;
    // ==========================================
    // register read path
    logic [DATA_W-1:0] rdata_reg;
    logic              oe_reg;
    logic              rd_done_reg;
    // drive follows the overlap, whichever edge comes first
    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_reg   <= DATA_RST;
            oe_reg      <= 1'b0;
            rd_done_reg <= 1'b0;
        end else begin
            rdata_reg   <= reg_rd_data;
            oe_reg      <= rd_act;
            rd_done_reg <= rd_end;
        end
    end
    assign db_out      = rdata_reg;
    assign db_oe       = oe_reg;
    assign reg_rd_done = rd_done_reg;
    // ==========================================
    // interrupt alert
    logic       pending_reg;
    logic       alert_reg;
    logic [1:0] hold_reg;
    logic [1:0] hold_next;
    wire        isr_reading;
    wire        pending_next;
    wire        alert_next;
    // a new event in the clearing cycle survives: set wins
    assign isr_reading  = rd_act & isr_hit;
    assign pending_next = irq_event | (pending_reg & ~isr_start);
    // the hold-off starts as the status read ends
    assign hold_next = (rd_end & rd_act_reg & isr_hit) ? HOLD_LOAD :
                       (hold_reg != HOLD_W_RST) ?
                       2'(hold_reg - 1'b1) : HOLD_W_RST;
    // alert stays down while reading and during the hold-off
    assign alert_next = pending_next & ~isr_reading &
                        (hold_next == HOLD_W_RST);
    always_ff @(posedge clk) begin
        if (reset) begin
            pending_reg <= 1'b0;
            alert_reg   <= 1'b0;
            hold_reg    <= HOLD_W_RST;
        end else begin
            pending_reg <= pending_next;
            alert_reg   <= alert_next;
            hold_reg    <= hold_next;
        end
    end
    assign int_n = ~alert_reg;
    // ==========================================
    // dma write path
    logic              dma_act_reg;
    logic [DATA_W-1:0] dma_data_reg;
    logic              push_reg;
    logic              req_reg;
    wire               dma_act;
    wire               dma_end;
    wire               fifo_ready;
    wire               req_next;
    // grant and strobe may come in either order
    assign dma_act = grant_s & wr_s & dma_write_en;
    assign dma_end = dma_act_reg & ~dma_act;
    always_ff @(posedge clk) begin
        if (reset) begin
            dma_act_reg  <= 1'b0;
            dma_data_reg <= DATA_RST;
            push_reg     <= 1'b0;
        end else begin
            dma_act_reg <= dma_act;
            if (dma_act) begin
                dma_data_reg <= db_s;
            end
            push_reg <= dma_end;
        end
    end
    // request drops for a cycle after each push and while the fifo is full; once dropped it returns
    // only with the grant released, never inside a half-done cycle
    assign req_next = dma_write_en & fifo_ready &
                      ~push_reg &
                      (req_reg | ~grant_s);
    always_ff @(posedge clk) begin
        if (reset) begin
            req_reg <= 1'b0;
        end else begin
            req_reg <= req_next;
        end
    end
    assign dma_request = req_reg;
    // ==========================================
    // fifo toward the scsi side
    // a byte pushed while full is dropped; the request
    // handshake is what keeps the controller from doing that
    byte_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk       (clk),
        .reset     (reset),
        .in_data   (dma_data_reg),
        .in_valid  (push_reg),
        .in_ready  (fifo_ready),
        .out_data  (scsi_data),
        .out_valid (scsi_valid),
        .out_ready (scsi_ready)
    );
endmodule
`default_nettype wire
